//--- common/capture_pkg.sv
// Operation
// R1: Mode 011 rising, 010 falling edge capture
// R2: Modes 100/101 capture every 4th/16th rise
// R3: Mode 001 both edges, interrupt each capture
// R4: Modes 000 and 110 leave unit disabled
// R5: Mode 111 rising edge wakes from Sleep/Idle
// R6: Interrupt after 1st to 4th capture
// R7: Time base select picks counter clock source
// R8: Not-empty flag set while FIFO holds data
// R9: Overflow flag shows capture overflow occurred
// R10: Halt-in-idle stops unit during CPU Idle
// R11: Cascade bit joins odd and even unit
// R12: Odd gives low half, even high half
// R13: Cascaded even unit follows odd unit's run
// R14: Synchronous units held reset until source enabled
// R15: Trigger select: wait trigger or synchronise
// R16: Trigger status set on trigger; zero holds counter
// R17: Sync source field selects sync/trigger source
// R18: Comparator/converter/charge codes are trigger only
// R19: Software disables source, drains FIFO first
// R20: Software sets time base before enabling
// R21: Software cascades even unit first, same settings
// R22: Cascaded mode and interrupt taken from odd unit
// R23: Counter counts up, wraps; capture pushes value
// R24: FIFO holds four captured values
// R25: Sync event resets counter to zero
// R26: Software trigger starts on trigger status write
// R27: Capture into full FIFO sets overflow, discarded
// R28: Mode off flushes FIFO, flags and counters
package capture_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0]  CONTROL_ONE_OFFSET = 4'h0;
    localparam logic [3:0]  CONTROL_TWO_OFFSET = 4'h4;
    localparam logic [3:0]  FIFO_PORT_OFFSET   = 4'h8;
    localparam logic [3:0]  COUNTER_OFFSET     = 4'hC;
    localparam logic [15:0] CONTROL_ONE_RESET  = 16'h0000;
    localparam logic [15:0] CONTROL_TWO_RESET  = 16'h000D;

    // ==========================================================
    // Field codes
    localparam logic [2:0] MODE_OFF      = 3'h0;
    localparam logic [2:0] MODE_BOTH     = 3'h1;
    localparam logic [2:0] MODE_FALL     = 3'h2;
    localparam logic [2:0] MODE_RISE     = 3'h3;
    localparam logic [2:0] MODE_RISE_4   = 3'h4;
    localparam logic [2:0] MODE_RISE_16  = 3'h5;
    localparam logic [2:0] MODE_UNUSED   = 3'h6;
    localparam logic [2:0] MODE_WAKE     = 3'h7;
    localparam logic [3:0] PRESCALE_4_LAST  = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

    localparam logic [2:0] TB_TIMER3 = 3'h0;
    localparam logic [2:0] TB_TIMER2 = 3'h1;
    localparam logic [2:0] TB_TIMER4 = 3'h2;
    localparam logic [2:0] TB_TIMER5 = 3'h3;
    localparam logic [2:0] TB_TIMER1 = 3'h4;
    localparam logic [2:0] TB_SYSTEM = 3'h7;

    localparam logic [4:0] SYNC_NONE        = 5'h00;
    localparam logic [4:0] SYNC_TRIG_ONLY_LO = 5'h18;
    localparam logic [4:0] SYNC_TRIG_ONLY_HI = 5'h1C;

    localparam int FIFO_DEPTH_DEFAULT = 4;
    localparam int DATA_WIDTH         = 16;

    // ==========================================================
    // Register layouts
    typedef struct packed {
        logic [1:0] unused_15_14;
        logic       halt_in_idle;
        logic [2:0] timebase_select;
        logic [2:0] unused_9_7;
        logic [1:0] captures_per_irq;
        logic       capture_overflow_flag;
        logic       buffer_not_empty_flag;
        logic [2:0] capture_mode_select;
    } control_one_t;

    typedef struct packed {
        logic [6:0] unused_15_9;
        logic       cascade_enable;
        logic       trigger_or_sync_select;
        logic       trigger_running_status;
        logic       unused_5;
        logic [4:0] sync_source_select;
    } control_two_t;

endpackage : capture_pkg

//--- verilog/capture_fifo.sv
`timescale 1ns/1ps
module capture_fifo
    import capture_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH,
    parameter int DEPTH = FIFO_DEPTH_DEFAULT
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic                  empty,
    output logic                  full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
        $error("capture_fifo: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd_ptr;
        logic [AW-1:0]               wr_ptr;
        logic [AW:0]                 count;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        do_push;
    logic        do_pop;

    assign head  = s_q.mem[s_q.rd_ptr];
    assign empty = (s_q.count == '0);
    assign full  = (s_q.count == (AW+1)'(DEPTH));

    always_comb begin
        s_d     = s_q;
        do_pop  = pop && !empty;
        // Full refuses the push so queued entries stay intact
        do_push = push && !full; // R27
        if (do_push) begin
            s_d.mem[s_q.wr_ptr] = push_data;
            s_d.wr_ptr          = s_q.wr_ptr + 1'b1;
        end
        if (do_pop) begin
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
        end
        case ({do_push, do_pop})
            2'b10:   s_d.count = s_q.count + 1'b1;
            2'b01:   s_d.count = s_q.count - 1'b1;
            default: s_d.count = s_q.count;
        endcase
        if (flush) begin
            s_d.rd_ptr = '0;
            s_d.wr_ptr = '0;
            s_d.count  = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : capture_fifo

//--- verilog/capture_edge.sv
`timescale 1ns/1ps
module capture_edge
    import capture_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pin_raw,
    input  wire logic [2:0] mode,
    input  wire logic       clear,
    input  wire logic       armed,
    output logic            capture,
    output logic            rise
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [3:0] presc;
        logic       capture;
        logic       rise;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;
    logic        is_rise;
    logic        is_fall;

    assign capture = s_q.capture;
    assign rise    = s_q.rise;

    always_comb begin
        s_d         = s_q;
        s_d.sync1   = pin_raw;
        s_d.sync2   = s_q.sync1;
        s_d.prev    = s_q.sync2;
        is_rise     = s_q.sync2 && !s_q.prev;
        is_fall     = !s_q.sync2 && s_q.prev;
        s_d.rise    = is_rise;
        s_d.capture = 1'b0;
        if (armed) begin
            case (mode)
                MODE_BOTH:  s_d.capture = is_rise || is_fall; // R3
                MODE_FALL:  s_d.capture = is_fall; // R1
                MODE_RISE:  s_d.capture = is_rise; // R1
                MODE_RISE_4, MODE_RISE_16: begin
                    if (is_rise) begin
                        if (s_q.presc == ((mode == MODE_RISE_4) ?
                                PRESCALE_4_LAST : PRESCALE_16_LAST)) begin
                            s_d.capture = 1'b1; // R2
                            s_d.presc   = '0;
                        end else begin
                            s_d.presc = s_q.presc + 1'b1;
                        end
                    end
                end
                default:    s_d.capture = 1'b0; // R4
            endcase
        end
        if (clear) begin
            s_d.presc = '0; // R28
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : capture_edge

//--- verilog/input_capture_fifo.sv
`timescale 1ns/1ps
module input_capture_fifo
    import capture_pkg::*;
#(
    parameter bit EVEN_UNIT  = 1'b0,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        WR_STROBE,
    input  wire logic        RD_STROBE,
    output logic      [15:0] RD_DATA,
    input  wire logic        CAPTURE_INPUT_PIN,
    input  wire logic [4:0]  TIMER_TICK,
    input  wire logic [31:0] SYNC_EVENT,
    input  wire logic [31:0] SYNC_SOURCE_ON,
    input  wire logic        CPU_IDLE,
    input  wire logic        CPU_SLEEP,
    input  wire logic        PEER_CAPTURE,
    input  wire logic        PEER_CARRY,
    input  wire logic        PEER_RUN,
    output logic             CAPTURE_IRQ,
    output logic             WAKE_IRQ,
    output logic             CAPTURE_OUT,
    output logic             CARRY_OUT,
    output logic             RUN_OUT
);

    // ==========================================================
    // Elaboration checks
    if (FIFO_DEPTH < 2) begin : g_check
        $error("input_capture_fifo: FIFO_DEPTH must be at least 2");
    end

    // ==========================================================
    // Helpers
    function automatic logic timebase_tick(
        input logic [2:0] sel,
        input logic [4:0] ticks
    );
        logic t;
        t = 1'b0;
        case (sel) // R7
            TB_TIMER1: t = ticks[0];
            TB_TIMER2: t = ticks[1];
            TB_TIMER3: t = ticks[2];
            TB_TIMER4: t = ticks[3];
            TB_TIMER5: t = ticks[4];
            TB_SYSTEM: t = 1'b1;
            default:   t = 1'b0;
        endcase
        return t;
    endfunction : timebase_tick

    function automatic logic mode_capturing(input logic [2:0] m);
        logic r;
        r = 1'b0;
        case (m)
            MODE_BOTH, MODE_FALL, MODE_RISE,
            MODE_RISE_4, MODE_RISE_16: r = 1'b1;
            default:                   r = 1'b0; // R4
        endcase
        return r;
    endfunction : mode_capturing

    function automatic logic trigger_only(input logic [4:0] sel);
        return (sel >= SYNC_TRIG_ONLY_LO) && (sel <= SYNC_TRIG_ONLY_HI);
    endfunction : trigger_only

    function automatic logic reg_hit(
        input logic       strobe,
        input logic [3:0] addr,
        input logic [3:0] offset
    );
        return strobe && (addr == offset);
    endfunction : reg_hit

    // ==========================================================
    // State
    typedef struct packed {
        control_one_t ctl1;
        control_two_t ctl2;
        logic [15:0]  counter;
        logic [1:0]   irq_count;
        logic         overflow;
        logic [15:0]  rd_data;
        logic         capture_irq;
        logic         wake_irq;
        logic         capture_out;
        logic         carry_out;
        logic         run_out;
    } unit_state_t;

    unit_state_t s_q;
    unit_state_t s_d;

    logic        edge_capture;
    logic        edge_rise;
    logic        fifo_empty;
    logic        fifo_full;
    logic [15:0] fifo_head;
    logic        fifo_push;
    logic        fifo_pop;
    logic        fifo_flush;

    logic        cascaded_even;
    logic        unit_on;
    logic        halted;
    logic        trig_mode;
    logic [4:0]  src_sel;
    logic        src_event;
    logic        src_on;
    logic        hold_clear;
    logic        tick;
    logic        capture_evt;
    logic        wrote_one;
    logic        wrote_two;

    // ==========================================================
    // Mode and time base decode
    always_comb begin
        // The even half of a pair takes its timing from the odd half
        cascaded_even = EVEN_UNIT && s_q.ctl2.cascade_enable; // R11
        unit_on       = mode_capturing(s_q.ctl1.capture_mode_select);
        halted        = s_q.ctl1.halt_in_idle && CPU_IDLE; // R10
        trig_mode     = s_q.ctl2.trigger_or_sync_select; // R15
        src_sel       = s_q.ctl2.sync_source_select; // R17
        src_event     = (src_sel != SYNC_NONE) && SYNC_EVENT[src_sel];
        src_on        = SYNC_SOURCE_ON[src_sel];
        if (cascaded_even) begin
            hold_clear = !PEER_RUN; // R13
            tick       = PEER_CARRY; // R12
        end else if (trig_mode) begin
            hold_clear = !s_q.ctl2.trigger_running_status; // R16
            tick       = timebase_tick(s_q.ctl1.timebase_select,
                                       TIMER_TICK);
        end else begin
            // Until the sync source runs the counter stays in reset
            hold_clear = (src_sel != SYNC_NONE) && !src_on; // R14
            tick       = timebase_tick(s_q.ctl1.timebase_select,
                                       TIMER_TICK);
        end
    end

    // ==========================================================
    // Edge detection and prescaler
    capture_edge u_edge (
        .clk     (CLOCK),
        .rst     (RST),
        .pin_raw (CAPTURE_INPUT_PIN),
        .mode    (s_q.ctl1.capture_mode_select),
        .clear   (s_q.ctl1.capture_mode_select == MODE_OFF),
        .armed   (unit_on && !hold_clear && !halted),
        .capture (edge_capture),
        .rise    (edge_rise)
    );

    // ==========================================================
    // Capture FIFO
    always_comb begin
        // Cascaded even unit samples on the odd unit's registered capture pulse, unless halted
        if (cascaded_even) begin
            capture_evt = PEER_CAPTURE && !halted; // R22
        end else begin
            capture_evt = edge_capture && unit_on; // R1
        end
        fifo_push  = capture_evt; // R23
        fifo_pop   = reg_hit(RD_STROBE, ADDR, FIFO_PORT_OFFSET);
        fifo_flush = (s_q.ctl1.capture_mode_select == MODE_OFF) &&
                     !cascaded_even; // R28
    end

    capture_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (FIFO_DEPTH) // R24
    ) u_fifo (
        .clk       (CLOCK),
        .rst       (RST),
        .flush     (fifo_flush),
        .push      (fifo_push),
        .push_data (s_q.counter), // R23
        .pop       (fifo_pop),
        .head      (fifo_head),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    // ==========================================================
    // Next state
    always_comb begin
        s_d       = s_q;
        wrote_one = reg_hit(WR_STROBE, ADDR, CONTROL_ONE_OFFSET);
        wrote_two = reg_hit(WR_STROBE, ADDR, CONTROL_TWO_OFFSET);

        // Writable fields only; flags are rebuilt on read
        if (wrote_one) begin
            s_d.ctl1.halt_in_idle        = WR_DATA[13];
            s_d.ctl1.timebase_select     = WR_DATA[12:10];
            s_d.ctl1.captures_per_irq    = WR_DATA[6:5];
            s_d.ctl1.capture_mode_select = WR_DATA[2:0];
        end
        if (wrote_two) begin
            s_d.ctl2.cascade_enable         = WR_DATA[8];
            s_d.ctl2.trigger_or_sync_select = WR_DATA[7];
            // Software may set or clear; start of soft trigger
            s_d.ctl2.trigger_running_status = WR_DATA[6]; // R26
            s_d.ctl2.sync_source_select     = WR_DATA[4:0];
        end
        // Hardware trigger wins over a clearing write
        if (trig_mode && src_event && !cascaded_even) begin
            s_d.ctl2.trigger_running_status = 1'b1; // R16
        end

        // Counter
        s_d.carry_out = 1'b0;
        if (!unit_on && !cascaded_even) begin
            s_d.counter = '0; // R4
        end else if (hold_clear) begin
            s_d.counter = '0; // R16
        end else if (halted) begin
            s_d.counter = s_q.counter; // R10
        end else if (!trig_mode && src_event &&
                     !trigger_only(src_sel) && !cascaded_even) begin
            // Comparator-class codes never reset a synced counter
            s_d.counter = '0; // R25 R18
        end else if (tick) begin
            s_d.counter   = s_q.counter + 16'h0001; // R23
            s_d.carry_out = (s_q.counter == 16'hFFFF); // R12
        end

        // Overflow is sticky until the unit is switched off
        if (capture_evt && fifo_full) begin
            s_d.overflow = 1'b1; // R27
        end else if (fifo_flush) begin
            s_d.overflow = 1'b0; // R28
        end

        // Interrupt pacing
        s_d.capture_irq = 1'b0;
        if (fifo_flush) begin
            s_d.irq_count = '0; // R28
        end else if (capture_evt && !cascaded_even) begin
            if (s_q.ctl1.capture_mode_select == MODE_BOTH) begin
                s_d.capture_irq = 1'b1; // R3
                s_d.irq_count   = '0;
            end else if (s_q.irq_count ==
                         s_q.ctl1.captures_per_irq) begin
                s_d.capture_irq = 1'b1; // R6
                s_d.irq_count   = '0;
            end else begin
                s_d.irq_count = s_q.irq_count + 2'h1; // R6
            end
        end

        // Wake source ignores every other setting
        s_d.wake_irq = (s_q.ctl1.capture_mode_select == MODE_WAKE) &&
                       edge_rise && (CPU_SLEEP || CPU_IDLE); // R5

        s_d.capture_out = capture_evt;
        s_d.run_out     = unit_on && !hold_clear;

        // Read port: data stand only in the cycle after the strobe
        s_d.rd_data = 16'h0000;
        if (RD_STROBE) begin
            case (ADDR)
                CONTROL_ONE_OFFSET: begin
                    s_d.rd_data        = s_q.ctl1;
                    s_d.rd_data[15:14] = 2'h0;
                    s_d.rd_data[9:7]   = 3'h0;
                    s_d.rd_data[4]     = s_q.overflow; // R9
                    s_d.rd_data[3]     = !fifo_empty; // R8
                end
                CONTROL_TWO_OFFSET: begin
                    s_d.rd_data       = s_q.ctl2;
                    s_d.rd_data[15:9] = 7'h00;
                    s_d.rd_data[5]    = 1'b0;
                end
                FIFO_PORT_OFFSET: s_d.rd_data = fifo_head;
                COUNTER_OFFSET:   s_d.rd_data = s_q.counter;
                default:          s_d.rd_data = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s_q      <= '0;
            s_q.ctl1 <= CONTROL_ONE_RESET;
            s_q.ctl2 <= CONTROL_TWO_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign RD_DATA     = s_q.rd_data;
    assign CAPTURE_IRQ = s_q.capture_irq;
    assign WAKE_IRQ    = s_q.wake_irq;
    assign CAPTURE_OUT = s_q.capture_out;
    assign CARRY_OUT   = s_q.carry_out;
    assign RUN_OUT     = s_q.run_out;

endmodule : input_capture_fifo

//--- verification/capture_source_model.sv
`timescale 1ns/1ps
module capture_source_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    output logic            pin   = 1'b0,
    output logic [4:0]      ticks = 5'h00
);
    logic [1:0] phase_q = 2'h0;

    // ==========================================================
    // Pulse source
    // Pin toggles every 4th cycle while go is high and holds between
    // bursts, so 4*n cycles of go give exactly n edges
    always @(posedge clk) begin
        if (rst || !go) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h3) begin
                pin <= ~pin;
            end
        end
        ticks <= rst ? 5'h00 : ~ticks;
    end
endmodule : capture_source_model

//--- verification/input_capture_fifo_asserts.sv
`timescale 1ns/1ps
module input_capture_fifo_asserts (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic [3:0]  ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic        WR_STROBE,
    input wire logic        RD_STROBE,
    input wire logic [15:0] RD_DATA,
    input wire logic        CAPTURE_INPUT_PIN,
    input wire logic        CPU_IDLE,
    input wire logic        CPU_SLEEP,
    input wire logic        CAPTURE_IRQ,
    input wire logic        WAKE_IRQ,
    input wire logic        CAPTURE_OUT,
    input wire logic        RUN_OUT
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // ==========================================================
    // Register port
    rd_idle_zero_a: assert property (
        !$past(RD_STROBE) |-> RD_DATA == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (
        RD_STROBE && ADDR[1:0] != 2'b00 |=> RD_DATA == 16'h0000)
        else $error("unmapped address read not zero");
    // Only writable fields echo; bits 9-7 and 15-14 read zero
    ctl_one_echo_a: assert property (
        WR_STROBE && ADDR == 4'h0 ##2 RD_STROBE && ADDR == 4'h0 |=>
        RD_DATA[15:5] == ($past(WR_DATA[15:5], 3) & 11'h1E3))
        else $error("control one fields do not read back");

    // ==========================================================
    // Capture path
    capture_pulse_a: assert property (
        CAPTURE_OUT |=> !CAPTURE_OUT)
        else $error("capture pulse longer than one cycle");
    quiet_pin_a: assert property (
        $stable(CAPTURE_INPUT_PIN)[*8] |-> !CAPTURE_OUT)
        else $error("capture without an input edge");
    irq_with_capture_a: assert property (
        CAPTURE_IRQ |-> CAPTURE_OUT)
        else $error("capture interrupt without a capture");
    wake_sleep_a: assert property (
        (!CPU_SLEEP && !CPU_IDLE)[*6] |-> !WAKE_IRQ)
        else $error("wake interrupt while awake");
    held_no_capture_a: assert property (
        (!RUN_OUT)[*6] |-> !CAPTURE_OUT)
        else $error("capture while counter held");
endmodule : input_capture_fifo_asserts

bind input_capture_fifo input_capture_fifo_asserts chk (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA),
    .CAPTURE_INPUT_PIN(CAPTURE_INPUT_PIN), .CPU_IDLE(CPU_IDLE),
    .CPU_SLEEP(CPU_SLEEP), .CAPTURE_IRQ(CAPTURE_IRQ),
    .WAKE_IRQ(WAKE_IRQ), .CAPTURE_OUT(CAPTURE_OUT), .RUN_OUT(RUN_OUT));

//--- verification/input_capture_fifo_tb.sv
`timescale 1ns/1ps
module input_capture_fifo_tb;
    import capture_pkg::*;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [3:0]  addr  = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr_s  = 1'b0;
    logic        rd_s  = 1'b0;
    logic        go    = 1'b0;
    logic        idle  = 1'b0;
    logic        sleep = 1'b0;
    logic        sev   = 1'b0;
    logic        son   = 1'b0;
    logic [15:0] rdata;
    logic        pin;
    logic [4:0]  ticks;
    logic        irq;
    logic        wake;
    logic        run;
    int          bad_count = 0;
    int          n_tests   = 0;
    int          irq_n     = 0;
    int          cycles    = 0;

    always #2.5 clk = ~clk;

    capture_source_model SRC (.clk(clk), .rst(rst), .go(go), .pin(pin),
        .ticks(ticks));

    input_capture_fifo DUT (.CLOCK(clk), .RST(rst), .ADDR(addr),
        .WR_DATA(wdata), .WR_STROBE(wr_s), .RD_STROBE(rd_s),
        .RD_DATA(rdata), .CAPTURE_INPUT_PIN(pin), .TIMER_TICK(ticks),
        .SYNC_EVENT({32{sev}}), .SYNC_SOURCE_ON({32{son}}),
        .CPU_IDLE(idle), .CPU_SLEEP(sleep), .PEER_CAPTURE(1'b0),
        .PEER_CARRY(1'b0), .PEER_RUN(1'b0), .CAPTURE_IRQ(irq),
        .WAKE_IRQ(wake), .CAPTURE_OUT(), .CARRY_OUT(), .RUN_OUT(run));

    // ==========================================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq === 1'b1 || wake === 1'b1) begin
            irq_n++;
        end
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Scenarios
    task automatic regs_at_reset;
        logic [15:0] v;
        rd(4'h0, v);
        chk(v, 16'h0000);
        rd(4'h4, v);
        chk(v, 16'h000D);
        rd(4'h2, v);
        chk(v, 16'h0000);
        wr(4'h4, 16'h0000);
    endtask : regs_at_reset

    // Time base goes in with the unit off, then the mode is set
    task automatic capt(input logic [15:0] c1, input logic [1:0] lp,
            input int tog, input int caps, input logic [15:0] dlt,
            input int irqs);
        logic [15:0] v;
        logic [15:0] prev;
        logic [15:0] flags;
        int          n0;
        flags = {11'h000, caps > 4, caps > 0, 3'h0};
        wr(4'h0, c1 & 16'hFFF8);
        rd(4'h0, v);
        chk(v, c1 & 16'hFFF8);
        {sleep, idle} <= lp;
        wr(4'h0, c1);
        n0 = irq_n;
        go <= 1'b1;
        repeat (4 * tog) @(posedge clk);
        go <= 1'b0;
        repeat (10) @(posedge clk);
        rd(4'h0, v);
        chk(v, c1 | flags);
        for (int i = 0; i < (caps > 4 ? 4 : caps); i++) begin
            rd(4'h8, v);
            if (i > 0) chk(v - prev, dlt);
            prev = v;
        end
        rd(4'h0, v);
        chk(v, c1 | (flags & 16'h0010));
        chk(16'(irq_n - n0), 16'(irqs));
        {sleep, idle} <= 2'b00;
    endtask : capt

    // Counter is held until software sets the running status
    task automatic trig;
        logic [15:0] v;
        wr(4'h4, 16'h0080);
        wr(4'h0, 16'h1C03);
        repeat (4) @(posedge clk);
        chk({15'h0000, run}, 16'h0000);
        rd(4'hC, v);
        chk(v, 16'h0000);
        wr(4'h4, 16'h00C0);
        repeat (4) @(posedge clk);
        chk({15'h0000, run}, 16'h0001);
        rd(4'h4, v);
        chk(v, 16'h00C0);
        wr(4'h0, 16'h1C00);
        wr(4'h4, 16'h0000);
    endtask : trig

    // Sync source gates and clears the counter; events set trigger
    task automatic sync_run;
        logic [15:0] v;
        wr(4'h4, 16'h000B);
        wr(4'h0, 16'h1C03);
        repeat (4) @(posedge clk);
        chk({15'h0000, run}, 16'h0000);
        son <= 1'b1;
        repeat (20) @(posedge clk);
        sev <= 1'b1;
        @(posedge clk);
        sev <= 1'b0;
        rd(4'hC, v);
        chk(v, 16'h0001);
        wr(4'h4, 16'h008B);
        sev <= 1'b1;
        @(posedge clk);
        sev <= 1'b0;
        rd(4'h4, v);
        chk(v, 16'h00CB);
    endtask : sync_run

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        regs_at_reset();
        capt(16'h1C03, 2'b00, 8, 4, 16'h0008, 4);
        capt(16'h1C02, 2'b00, 8, 4, 16'h0008, 4);
        capt(16'h1C61, 2'b00, 4, 4, 16'h0004, 4);
        capt(16'h1C04, 2'b00, 16, 2, 16'h0020, 2);
        capt(16'h1C05, 2'b00, 64, 2, 16'h0080, 2);
        capt(16'h1C23, 2'b00, 8, 4, 16'h0008, 2);
        capt(16'h1C43, 2'b00, 12, 6, 16'h0008, 2);
        capt(16'h1003, 2'b00, 8, 4, 16'h0004, 4);
        capt(16'h1C00, 2'b00, 8, 0, 16'h0000, 0);
        capt(16'h1C06, 2'b00, 8, 0, 16'h0000, 0);
        capt(16'h3C03, 2'b01, 8, 0, 16'h0000, 0);
        capt(16'h1C07, 2'b10, 8, 0, 16'h0000, 4);
        sync_run();
        trig();
        tally_and_finish();
    end
endmodule : input_capture_fifo_tb
